// >>> ifd_pkg.sv
package ifd_pkg;
  // Clock and hold time for the restart input
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned RESTART_HOLD_MS = 1000;
  localparam int unsigned RESTART_HOLD_CYC = CLK_HZ / 1000 * RESTART_HOLD_MS;

  // Port function codes
  localparam int FSEL_W = 5;
  localparam logic [4:0] FN_NONE = 5'h00;
  localparam logic [4:0] FN_RESTART = 5'h03;
  localparam logic [4:0] FN_SERVO = 5'h04;
  localparam logic [4:0] FN_AUTO_START = 5'h05;
  localparam logic [4:0] FN_PAUSE = 5'h07;
  localparam logic [4:0] FN_PAUSE_CLR = 5'h08;
  localparam logic [4:0] FN_ERR_RESET = 5'h10;
  localparam logic [4:0] FN_HOME = 5'h12;

  // Register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATE = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h010;
  localparam logic [11:0] ADDR_FSEL_BASE = 12'h040;

  // Control fields and reset values
  localparam int CTRL_IOMON_BIT = 0;
  localparam int CTRL_AUTOSTART_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int STATE_SERVO_BIT = 0;
  localparam int STATE_PAUSE_BIT = 1;
  localparam int STATE_AUTO_BIT = 2;
  localparam int STATE_IN_LSB = 8;
  localparam int EV_W = 9;
  localparam logic [EV_W-1:0] IRQ_EN_RESET = 9'h000;

  typedef struct packed {
    logic restart;
    logic servo_on;
    logic servo_off;
    logic auto_start;
    logic auto_end;
    logic pause;
    logic pause_clr;
    logic err_reset;
    logic home_start;
  } ifd_cmd_t;

  typedef enum logic [1:0] {
    AUTO_IDLE = 2'b01,
    AUTO_RUN = 2'b10
  } ifd_auto_t;
endpackage : ifd_pkg

// >>> ifd_dispatch.sv
// Operation
// R1: Function 3 port held high one second without break issues a software restart.
// R2: Function 4 port enables servo on rising edge, disables on falling edge.
// R3: Function 5 with auto-start setting 0 starts program on rise, ends on fall.
// R4: Default auto-start setting launches program after power-up or restart in auto mode.
// R5: Function 7 port pauses operation on its falling edge.
// R6: Function 8 port clears a pending pause on its rising edge.
// R7: External equipment keeps the pause input high during normal running.
// R8: Function 16 rising edge resets errors only of cancellation level or lower.
// R9: Function 18 rising edge starts home return only with servo enabled.
// R10: Monitor setting 0 suppresses I/O-board errors; 1 restores monitoring.
// R11: Each input port has its own function-selection setting, indexed by port.
// R12: Inputs synchronised; edges from current versus previous sample, one pulse each.
`timescale 1ns/1ps
module ifd_dispatch
  import ifd_pkg::*;
#(
  parameter int NUM_PORTS = 8,
  parameter int unsigned HOLD_CYC = RESTART_HOLD_CYC
) (
  // Clock and reset
  input logic clk_sys,
  input logic reset,
  // APB slave
  input logic [11:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Input port pins
  input logic [NUM_PORTS-1:0] in_port,
  // Controller state
  input logic auto_mode,
  input logic err_minor,
  // Commands and status
  output ifd_cmd_t cmd,
  output logic servo_en,
  output logic paused,
  output logic auto_run,
  output logic io_mon_en,
  output logic irq
);
  localparam int CW = $clog2(HOLD_CYC + 1);
  localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYC - 1);

  function automatic logic [NUM_PORTS-1:0] fn_mask(
    input logic [NUM_PORTS*FSEL_W-1:0] codes,
    input logic [4:0] want
  );
    logic [NUM_PORTS-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      m[i] = (codes[i*FSEL_W +: FSEL_W] == want);
    end
    return m;
  endfunction : fn_mask

  logic [NUM_PORTS-1:0] in_s1_r, in_s2_r, in_prev_r;
  logic [NUM_PORTS-1:0] rise, fall;
  logic [NUM_PORTS*FSEL_W-1:0] fsel_r;
  logic [NUM_PORTS-1:0] m_rst, m_srv, m_auto, m_pause, m_pclr, m_err, m_home;
  logic [1:0] ctrl_r;
  logic [EV_W-1:0] irq_stat_r, irq_en_r;
  logic [31:0] prdata_r;
  logic [CW-1:0] hold_cnt_r;
  logic hold_done_r;
  logic boot_pend_r;
  logic servo_en_r, paused_r;
  ifd_auto_t auto_r, auto_nxt;
  ifd_cmd_t cmd_r, cmd_nxt;
  logic acc, wr, setup;
  logic fsel_hit;
  logic [11:0] fsel_off;
  logic [$clog2(NUM_PORTS+1)-1:0] fsel_idx;
  logic addr_ok;
  logic hold_lvl;

  // R12 two-stage sync
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      in_s1_r <= '0;
      in_s2_r <= '0;
      in_prev_r <= '0;
    end else begin
      in_s1_r <= in_port;
      in_s2_r <= in_s1_r;
      in_prev_r <= in_s2_r;
    end
  end

  // R12 edge compare
  assign rise = in_s2_r & ~in_prev_r;
  assign fall = ~in_s2_r & in_prev_r;

  // R11 per-port selection
  assign m_rst = fn_mask(fsel_r, FN_RESTART);
  assign m_srv = fn_mask(fsel_r, FN_SERVO);
  assign m_auto = fn_mask(fsel_r, FN_AUTO_START);
  assign m_pause = fn_mask(fsel_r, FN_PAUSE);
  assign m_pclr = fn_mask(fsel_r, FN_PAUSE_CLR);
  assign m_err = fn_mask(fsel_r, FN_ERR_RESET);
  assign m_home = fn_mask(fsel_r, FN_HOME);

  // APB decode; the slave never waits
  assign setup = psel && !penable;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign fsel_off = paddr - ADDR_FSEL_BASE;
  assign fsel_hit = (paddr >= ADDR_FSEL_BASE) && (paddr[1:0] == 2'h0) &&
                    (fsel_off[11:2] < 10'(NUM_PORTS));
  assign fsel_idx = fsel_off[2 +: $clog2(NUM_PORTS+1)];
  assign addr_ok = fsel_hit || paddr == ADDR_CTRL || paddr == ADDR_STATE ||
                   paddr == ADDR_IRQ_STAT || paddr == ADDR_IRQ_CLR || paddr == ADDR_IRQ_EN;
  assign pready = 1'b1;
  assign pslverr = acc && !addr_ok;
  assign prdata = prdata_r;

  // Read data captured in setup so it is a flop by the access phase
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_r <= 32'h0000_0000;
      case (paddr)
        ADDR_CTRL: prdata_r[1:0] <= ctrl_r;
        ADDR_STATE: begin
          prdata_r[STATE_SERVO_BIT] <= servo_en_r;
          prdata_r[STATE_PAUSE_BIT] <= paused_r;
          prdata_r[STATE_AUTO_BIT] <= (auto_r == AUTO_RUN);
          prdata_r[STATE_IN_LSB +: NUM_PORTS] <= in_s2_r;
        end
        ADDR_IRQ_STAT: prdata_r[EV_W-1:0] <= irq_stat_r;
        ADDR_IRQ_EN: prdata_r[EV_W-1:0] <= irq_en_r;
        default: begin
          if (fsel_hit) begin
            prdata_r[FSEL_W-1:0] <= fsel_r[fsel_idx*FSEL_W +: FSEL_W];
          end
        end
      endcase
    end
  end

  // R10 monitor and auto-start settings
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr && paddr == ADDR_CTRL) begin
      ctrl_r <= pwdata[1:0];
    end
  end
  assign io_mon_en = ctrl_r[CTRL_IOMON_BIT];

  // R11 function-selection store
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fsel_r <= '0;
    end else if (wr && fsel_hit) begin
      fsel_r[fsel_idx*FSEL_W +: FSEL_W] <= pwdata[FSEL_W-1:0];
    end
  end

  // R1 hold timer; fires once per continuous hold
  assign hold_lvl = |(in_s2_r & m_rst);
  always_ff @(posedge clk_sys) begin
    if (reset || !hold_lvl) begin
      hold_cnt_r <= '0;
      hold_done_r <= 1'b0;
    end else if (hold_cnt_r == HOLD_LAST) begin
      hold_done_r <= 1'b1;
    end else begin
      hold_cnt_r <= hold_cnt_r + CW'(1);
    end
  end

  // R4 boot launch pending after power-up or restart
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      boot_pend_r <= 1'b1;
    end else begin
      boot_pend_r <= cmd_nxt.restart;
    end
  end

  always_comb begin
    cmd_nxt = '0;
    // R1 restart after hold
    cmd_nxt.restart = hold_lvl && hold_cnt_r == HOLD_LAST && !hold_done_r;
    // R2 servo edges
    cmd_nxt.servo_on = |(rise & m_srv);
    cmd_nxt.servo_off = |(fall & m_srv);
    // R3 input-driven program start and end
    cmd_nxt.auto_start = !ctrl_r[CTRL_AUTOSTART_BIT] && |(rise & m_auto);
    cmd_nxt.auto_end = !ctrl_r[CTRL_AUTOSTART_BIT] && |(fall & m_auto) &&
                       auto_r == AUTO_RUN;
    // R4 automatic launch
    if (boot_pend_r && ctrl_r[CTRL_AUTOSTART_BIT] && auto_mode) begin
      cmd_nxt.auto_start = 1'b1;
    end
    // R5 pause on falling edge
    cmd_nxt.pause = |(fall & m_pause);
    // R6 pause release on rising edge
    cmd_nxt.pause_clr = |(rise & m_pclr);
    // R8 error reset gated by severity
    cmd_nxt.err_reset = |(rise & m_err) && err_minor;
    // R9 home needs servo on
    cmd_nxt.home_start = |(rise & m_home) && servo_en_r;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmd_r <= '0;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end
  assign cmd = cmd_r;

  // R2 servo state; off edge wins if both land together
  always_ff @(posedge clk_sys) begin
    if (reset || cmd_nxt.restart || cmd_nxt.servo_off) begin
      servo_en_r <= 1'b0;
    end else if (cmd_nxt.servo_on) begin
      servo_en_r <= 1'b1;
    end
  end

  // R5 pause set wins over release, the safer choice
  always_ff @(posedge clk_sys) begin
    if (reset || cmd_nxt.restart) begin
      paused_r <= 1'b0;
    end else if (cmd_nxt.pause) begin
      paused_r <= 1'b1;
    end else if (cmd_nxt.pause_clr) begin
      paused_r <= 1'b0;
    end
  end
  assign servo_en = servo_en_r;
  assign paused = paused_r;

  always_comb begin
    case (auto_r)
      AUTO_IDLE: auto_nxt = cmd_nxt.auto_start ? AUTO_RUN : AUTO_IDLE;
      AUTO_RUN: auto_nxt = cmd_nxt.auto_end ? AUTO_IDLE : AUTO_RUN;
      default: auto_nxt = AUTO_IDLE;
    endcase
  end

  // R3 program run state
  always_ff @(posedge clk_sys) begin
    if (reset || cmd_nxt.restart) begin
      auto_r <= AUTO_IDLE;
    end else begin
      auto_r <= auto_nxt;
    end
  end
  assign auto_run = (auto_r == AUTO_RUN);

  // Sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr && paddr == ADDR_IRQ_CLR) ? pwdata[EV_W-1:0] : '0))
                    | cmd_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_en_r <= IRQ_EN_RESET;
    end else if (wr && paddr == ADDR_IRQ_EN) begin
      irq_en_r <= pwdata[EV_W-1:0];
    end
  end
  assign irq = |(irq_stat_r & irq_en_r);

  // R1 restart only at full hold
  AST_R1_HOLD: assert property (@(posedge clk_sys) disable iff (reset) // R1
    cmd_r.restart |-> $past(hold_cnt_r) == HOLD_LAST && $past(hold_lvl))
    else $error("restart without full hold");

  // R2 servo follows port edge
  AST_R2_SERVO: assert property (@(posedge clk_sys) disable iff (reset) // R2
    (|(rise & m_srv) && !(|(fall & m_srv)) && !cmd_nxt.restart) |=> servo_en_r ##0 cmd_r.servo_on)
    else $error("servo not enabled on rising edge");

  // R3 input start runs program
  AST_R3_START: assert property (@(posedge clk_sys) disable iff (reset) // R3
    (!ctrl_r[CTRL_AUTOSTART_BIT] && |(rise & m_auto) && !cmd_nxt.restart) |=> auto_run)
    else $error("program did not start on rising edge");

  // R4 boot launch in auto mode
  AST_R4_BOOT: assert property (@(posedge clk_sys) disable iff (reset) // R4
    (boot_pend_r && ctrl_r[CTRL_AUTOSTART_BIT] && auto_mode) |=> cmd_r.auto_start)
    else $error("no automatic launch after restart");

  // R5 pause on falling edge
  AST_R5_PAUSE: assert property (@(posedge clk_sys) disable iff (reset) // R5
    (|(fall & m_pause) && !cmd_nxt.restart) |=> paused_r)
    else $error("pause missed falling edge");

  // R6 release clears pause
  AST_R6_CLEAR: assert property (@(posedge clk_sys) disable iff (reset) // R6
    (paused_r && |(rise & m_pclr) && !(|(fall & m_pause))) |=> !paused_r)
    else $error("pause not cleared");

  // R8 severity gate
  AST_R8_ERR: assert property (@(posedge clk_sys) disable iff (reset) // R8
    cmd_r.err_reset |-> $past(err_minor) && $past(|(rise & m_err)))
    else $error("error reset not allowed");

  // R9 home needs servo
  AST_R9_HOME: assert property (@(posedge clk_sys) disable iff (reset) // R9
    cmd_r.home_start |-> $past(servo_en_r))
    else $error("home return without servo");

  // R10 monitor setting reaches output
  AST_R10_MON: assert property (@(posedge clk_sys) disable iff (reset) // R10
    (wr && paddr == ADDR_CTRL) |=> io_mon_en == $past(pwdata[CTRL_IOMON_BIT]))
    else $error("monitor setting not applied");

  // R12 one pulse per edge
  AST_R12_PULSE: assert property (@(posedge clk_sys) disable iff (reset) // R12
    cmd_r.servo_on |=> !cmd_r.servo_on)
    else $error("edge gave two pulses");

  // R11 selection write lands
  AST_R11_FSEL: assert property (@(posedge clk_sys) disable iff (reset) // R11
    (wr && fsel_hit) |=> fsel_r[$past(fsel_idx)*FSEL_W +: FSEL_W] == $past(pwdata[FSEL_W-1:0]))
    else $error("function selection not stored");

  COV_AUTO: cover property (@(posedge clk_sys) disable iff (reset)
    cmd_r.auto_start ##[1:50] cmd_r.auto_end);
  COV_RESTART: cover property (@(posedge clk_sys) disable iff (reset) cmd_r.restart);
  COV_PAUSE: cover property (@(posedge clk_sys) disable iff (reset)
    cmd_r.pause ##[1:50] cmd_r.pause_clr);
  COV_HOME: cover property (@(posedge clk_sys) disable iff (reset)
    servo_en_r ##1 cmd_r.home_start);
endmodule : ifd_dispatch

// >>> ifd_plc_model.sv
`timescale 1ns/1ps
module ifd_plc_model (
  // Clock
  input wire logic clk_sys,
  // Levels asked for by the bench
  input wire logic [7:0] want,
  // Pins into the dispatcher
  output logic [7:0] in_port
);
  // pause pin high except while the bench tests pause
  // The bench asks for the pause pin high from time zero; pins move just after an edge
  always_ff @(posedge clk_sys) begin
    in_port <= want;
  end
endmodule : ifd_plc_model

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  import ifd_pkg::*;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, auto_mode, err_minor;
  logic servo_en, paused, auto_run, io_mon_en, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] want, in_port, cur;
  ifd_cmd_t cmd;
  int err_count = 0, total_checks = 0, cnt[9], exp_cnt[9], seed = 40, hold;
  int codes[8] = '{3, 4, 5, 7, 8, 16, 18, 0};
  ifd_plc_model u_plc (.clk_sys(clk_sys), .want(want), .in_port(in_port));
  ifd_dispatch #(.NUM_PORTS(8), .HOLD_CYC(20)) i_ifd_dispatch (.clk_sys(clk_sys),
    .reset(reset), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_port(in_port), .auto_mode(auto_mode), .err_minor(err_minor), .cmd(cmd),
    .servo_en(servo_en), .paused(paused), .auto_run(auto_run), .io_mon_en(io_mon_en),
    .irq(irq));
  function automatic int rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed & 32'h7FFFFFFF;
  endfunction : rnd
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (e !== g) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (n == 50) err_count++;
    rd = pslverr ? 32'hFFFF_FFFF : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Random level on the unassigned pin keeps it toggling without effect
  task automatic pins(input logic [7:0] v);
    @(posedge clk_sys);
    cur = v;
    want <= {rnd() % 2 == 1, v[6:0]};
    repeat (6) @(posedge clk_sys);
  endtask : pins
  task automatic cc(input int i);
    chk("cmd_count", exp_cnt[i], cnt[i]);
  endtask : cc
  always @(posedge clk_sys) begin
    for (int i = 0; i < 9; i++) if (!reset && cmd[i] === 1'b1) cnt[i]++;
  end
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #(4 * 20000);
    err_count++;
    results();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    reset = 1'b1;
    auto_mode = 1'b1;
    err_minor = 1'b0;
    want = 8'h08;
    cur = 8'h08;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (6) @(posedge clk_sys);
    exp_cnt[5] = 1;
    chk("io_mon_en", 1, io_mon_en);
    chk("auto_run", 1, auto_run);
    cc(5);
    apb(1, ADDR_CTRL, 32'h1);
    for (int i = 0; i < 8; i++) apb(1, ADDR_FSEL_BASE + 12'(4 * i), 32'(codes[i]));
    apb(0, ADDR_FSEL_BASE + 12'h014, 0);
    chk("fsel5", 32'h10, rd);
    apb(0, 12'h0F0, 0);
    chk("unmapped", 32'hFFFF_FFFF, rd);
    $display("test setup done");
    pins(8'h0A); exp_cnt[7]++;
    chk("servo_en", 1, servo_en); cc(7);
    pins(8'h4A); exp_cnt[0]++;
    cc(0);
    // Short hold stays below the restart count: the pin stays high 7 + hold cycles
    hold = 2 + rnd() % 10;
    pins(8'h0B); repeat (hold) @(posedge clk_sys); pins(8'h0A);
    cc(8);
    pins(8'h0B); repeat (30) @(posedge clk_sys); pins(8'h0A); exp_cnt[8]++;
    cc(8); chk("servo_after_restart", 0, servo_en); chk("auto_after_restart", 0, auto_run);
    pins(8'h08); pins(8'h48);
    cc(0);
    $display("test servo restart home done");
    pins(8'h0C); exp_cnt[5]++;
    chk("auto_run", 1, auto_run); cc(5);
    pins(8'h08); exp_cnt[4]++;
    chk("auto_run", 0, auto_run); cc(4);
    pins(8'h00); exp_cnt[3]++;
    chk("paused", 1, paused); cc(3);
    pins(8'h10); exp_cnt[2]++;
    chk("paused", 0, paused); cc(2);
    pins(8'h38); pins(8'h18);
    cc(1);
    err_minor <= 1'b1;
    apb(1, ADDR_IRQ_CLR, 32'h1FF);
    apb(1, ADDR_IRQ_EN, 32'h2);
    chk("irq", 0, irq);
    pins(8'h38); exp_cnt[1]++;
    cc(1); chk("irq", 1, irq);
    apb(0, ADDR_IRQ_STAT, 0);
    chk("irq_stat", 32'h2, rd);
    apb(1, ADDR_IRQ_CLR, 32'h2);
    apb(0, ADDR_IRQ_STAT, 0);
    chk("irq_stat", 0, rd); chk("irq", 0, irq);
    $display("test program pause error irq done");
    apb(1, ADDR_CTRL, 32'h0); repeat (2) @(posedge clk_sys);
    chk("io_mon_en", 0, io_mon_en);
    apb(1, ADDR_CTRL, 32'h1); repeat (2) @(posedge clk_sys);
    chk("io_mon_en", 1, io_mon_en);
    $display("test monitor done");
    results();
  end
endmodule : testbench
